// ### shared/panel_pkg.sv
// Purpose: Shared constants and types for the front-panel monitor encoder.
// Assumes: Segment bit 0 is the top segment a, bit 6 the middle segment g, active high.
// Notes:   Digit 0 is the rightmost of the six digits.
package panel_pkg;

  localparam int DIGITS = 6;
  localparam int SEG_W  = 7;
  localparam int CODE_W = 5;
  localparam int LINES  = 10;
  localparam int IO_DIGITS = 5;

  // Segment positions inside a digit.
  localparam int SEG_A = 0;
  localparam int SEG_B = 1;
  localparam int SEG_F = 5;
  localparam logic [SEG_W-1:0] LOWER_MASK = 7'h1c;

  // Banner timing.
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned BANNER_MS  = 1000;
  localparam int unsigned BANNER_CYCLES_DEF = (CLK_HZ / 1000) * BANNER_MS;
  localparam int BANNER_CNT_W = 26;

  // Glyph codes fed to the digit encoder; 0 to 15 are hex digits.
  localparam logic [CODE_W-1:0] G_HEX_0   = 5'h00;
  localparam logic [CODE_W-1:0] G_HEX_A   = 5'h0a;
  localparam logic [CODE_W-1:0] G_HEX_D   = 5'h0d;
  localparam logic [CODE_W-1:0] G_HEX_E   = 5'h0e;
  localparam logic [CODE_W-1:0] G_BLANK   = 5'h10;
  localparam logic [CODE_W-1:0] G_LET_R   = 5'h11;
  localparam logic [CODE_W-1:0] G_LET_S   = 5'h12;
  localparam logic [CODE_W-1:0] G_LET_Y   = 5'h13;
  localparam logic [CODE_W-1:0] G_ST_INIT = 5'h14;
  localparam logic [CODE_W-1:0] G_ST_RDY  = 5'h15;
  localparam logic [CODE_W-1:0] G_ST_WAIT = 5'h16;
  localparam logic [CODE_W-1:0] G_ST_RUN  = 5'h17;
  localparam logic [CODE_W-1:0] G_ST_STOP = 5'h18;

  // Segment patterns.
  localparam logic [SEG_W-1:0] P_HEX [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d,
    7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
  localparam logic [SEG_W-1:0] P_BLANK   = 7'h00;
  localparam logic [SEG_W-1:0] P_LET_R   = 7'h50;
  localparam logic [SEG_W-1:0] P_LET_S   = 7'h6d;
  localparam logic [SEG_W-1:0] P_LET_Y   = 7'h6e;
  localparam logic [SEG_W-1:0] P_ST_INIT = 7'h01;
  localparam logic [SEG_W-1:0] P_ST_RDY  = 7'h41;
  localparam logic [SEG_W-1:0] P_ST_WAIT = 7'h49;
  localparam logic [SEG_W-1:0] P_ST_RUN  = 7'h3f;
  localparam logic [SEG_W-1:0] P_ST_STOP = 7'h36;

  typedef enum logic [1:0] {
    PAGE_SERVO = 2'h0,
    PAGE_SPEED = 2'h1,
    PAGE_LINE  = 2'h3
  } page_type;

  typedef enum logic [2:0] {
    DRV_INIT  = 3'h0,
    DRV_READY = 3'h1,
    DRV_WAIT  = 3'h3,
    DRV_RUN   = 3'h2,
    DRV_STOP  = 3'h6
  } drive_state_type;

  typedef enum logic {
    ST_BANNER = 1'b0,
    ST_SHOW   = 1'b1
  } disp_state_type;

endpackage

// ### rtl/glyph_encoder.sv
// Purpose: Turns one glyph code into a seven-segment pattern.
// Assumes: Codes below 16 are hex digits.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module glyph_encoder
  import panel_pkg::*;
(
  input  wire logic [panel_pkg::CODE_W-1:0] i_code,
  output logic      [panel_pkg::SEG_W-1:0]  o_seg
);

  import panel_pkg::*;

  always_comb
  begin
    case (i_code)
      G_BLANK:   o_seg = P_BLANK;
      G_LET_R:   o_seg = P_LET_R;
      G_LET_S:   o_seg = P_LET_S;
      G_LET_Y:   o_seg = P_LET_Y;
      G_ST_INIT: o_seg = P_ST_INIT;
      G_ST_RDY:  o_seg = P_ST_RDY;
      G_ST_WAIT: o_seg = P_ST_WAIT;
      G_ST_RUN:  o_seg = P_ST_RUN;
      G_ST_STOP: o_seg = P_ST_STOP;
      default:
      begin
        if (i_code[CODE_W-1])
          o_seg = P_BLANK;
        else
          o_seg = P_HEX[i_code[3:0]];
      end
    endcase
  end

endmodule

// ### rtl/panel_monitor_display_encoder.sv
// Purpose: Formats the servo-state, motor-speed and line-status pages for six LED digits.
// Assumes: All inputs are synchronous to i_clk; speed arrives as four BCD digits.
// Notes:   o_seg holds digit 0 (rightmost) in its low seven bits.
`timescale 1ns/10ps
// Operation
// - First digit shows drive state glyph.
// - Second digit shows fieldbus link code.
// - Disabled drive: speed page shows s 0.
// - Enabled drive: speed page shows r speed.
// - Line page uses upper-half segments only.
// - Decimal points lit for input view only.
// - Ten inputs map to ascending positions.
// - Ten outputs map to ascending positions.
// - Ready banner one second, then page or alarm.
module panel_monitor_display_encoder
  import panel_pkg::*;
#(
  parameter int unsigned BANNER_CYCLES = panel_pkg::BANNER_CYCLES_DEF
)
(
  input  wire logic                                    i_clk,
  input  wire logic                                    i_sys_rst,
  input  wire logic                                    i_ce,
  input  wire panel_pkg::page_type                     i_page,
  input  wire panel_pkg::drive_state_type              i_drive_state,
  input  wire logic [3:0]                              i_link_code,
  input  wire logic                                    i_drive_enabled,
  input  wire logic [15:0]                             i_speed_bcd,
  input  wire logic                                    i_line_input_view,
  input  wire logic [panel_pkg::LINES-1:0]             i_inputs,
  input  wire logic [panel_pkg::LINES-1:0]             i_outputs,
  input  wire logic                                    i_alarm_present,
  input  wire logic [7:0]                              i_alarm_code,
  output logic      [panel_pkg::DIGITS*panel_pkg::SEG_W-1:0] o_seg,
  output logic      [panel_pkg::DIGITS-1:0]            o_dp
);

  import panel_pkg::*;

  localparam logic [BANNER_CNT_W-1:0] BANNER_LAST = BANNER_CNT_W'(BANNER_CYCLES - 1);

  disp_state_type           state;
  disp_state_type           next_state;
  logic [BANNER_CNT_W-1:0]  count;
  logic [BANNER_CNT_W-1:0]  next_count;
  logic [CODE_W-1:0]        code   [DIGITS];
  logic [SEG_W-1:0]         glyph  [DIGITS];
  logic [SEG_W-1:0]         io_seg [DIGITS];
  logic [LINES-1:0]         lines;
  logic [DIGITS*SEG_W-1:0]  next_seg;
  logic [DIGITS-1:0]        next_dp;
  logic                     page_live;

  // Banner timer then page display.
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      ST_BANNER:
      begin
        if (count == BANNER_LAST)
          next_state = ST_SHOW;
        else
          next_count = count + 1'b1;
      end
      ST_SHOW:
        next_state = ST_SHOW;
      default:
        next_state = ST_BANNER;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state <= ST_BANNER;
      count <= '0;
    end
    else if (i_ce)
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign page_live = (state == ST_SHOW) && !i_alarm_present;

  // Glyph choice per digit.
  always_comb
  begin
    for (int d = 0; d < DIGITS; d++)
      code[d] = G_BLANK;
    if (state == ST_BANNER)
    begin
      code[4] = G_LET_R;
      code[3] = G_HEX_E;
      code[2] = G_HEX_A;
      code[1] = G_HEX_D;
      code[0] = G_LET_Y;
    end
    else if (i_alarm_present)
    begin
      code[5] = G_HEX_E;
      code[4] = G_LET_R;
      code[1] = {1'b0, i_alarm_code[7:4]};
      code[0] = {1'b0, i_alarm_code[3:0]};
    end
    else
    begin
      case (i_page)
        PAGE_SERVO:
        begin
          case (i_drive_state)
            DRV_INIT:  code[5] = G_ST_INIT;
            DRV_READY: code[5] = G_ST_RDY;
            DRV_WAIT:  code[5] = G_ST_WAIT;
            DRV_RUN:   code[5] = G_ST_RUN;
            DRV_STOP:  code[5] = G_ST_STOP;
            default:   code[5] = G_BLANK;
          endcase
          code[4] = {1'b0, i_link_code};
        end
        PAGE_SPEED:
        begin
          if (i_drive_enabled)
          begin
            code[5] = G_LET_R;
            for (int d = 0; d < 4; d++)
              code[d] = {1'b0, i_speed_bcd[4*d +: 4]};
          end
          else
          begin
            code[5] = G_LET_S;
            code[0] = G_HEX_0;
          end
        end
        default:
          code[5] = G_BLANK;
      endcase
    end
  end

  assign lines = i_line_input_view ? i_inputs : i_outputs;

  genvar g;
  generate
    for (g = 0; g < DIGITS; g++)
    begin : gen_digit
      glyph_encoder u_enc (
        .i_code (code[g]),
        .o_seg  (glyph[g])
      );
      if (g < IO_DIGITS)
      begin : gen_io
        always_comb
        begin
          io_seg[g] = P_BLANK;
          io_seg[g][SEG_B] = lines[2*g];
          io_seg[g][SEG_F] = lines[2*g+1];
        end
      end
      else
      begin : gen_pad
        assign io_seg[g] = P_BLANK;
      end
      assign next_seg[g*SEG_W +: SEG_W] =
        (page_live && i_page == PAGE_LINE) ? io_seg[g] : glyph[g];
    end
  endgenerate

  assign next_dp = (page_live && i_page == PAGE_LINE && i_line_input_view) ? '1 : '0;

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_seg <= '0;
      o_dp  <= '0;
    end
    else if (i_ce)
    begin
      o_seg <= next_seg;
      o_dp  <= next_dp;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence s_line_page;
    i_ce && page_live && i_page == PAGE_LINE;
  endsequence

  AST_BANNER_LEN: assert property (
    (state == ST_SHOW) && ($past(state) == ST_BANNER) |-> $past(count) == BANNER_LAST)
    else $error("banner left before its full time");
  AST_BANNER_TEXT: assert property (
    i_ce && state == ST_BANNER |=> o_seg[4*SEG_W +: SEG_W] == P_LET_R && o_seg[6:0] == P_LET_Y)
    else $error("ready banner not shown");
  AST_RUN_RING: assert property (
    i_ce && page_live && i_page == PAGE_SERVO && i_drive_state == DRV_RUN
    |=> o_seg[5*SEG_W +: SEG_W] == P_ST_RUN)
    else $error("running state not shown as ring");
  AST_LINK_CODE: assert property (
    i_ce && page_live && i_page == PAGE_SERVO
    |=> o_seg[4*SEG_W +: SEG_W] == P_HEX[$past(i_link_code)])
    else $error("link code digit wrong");
  AST_SPEED_OFF: assert property (
    i_ce && page_live && i_page == PAGE_SPEED && !i_drive_enabled
    |=> o_seg[5*SEG_W +: SEG_W] == P_LET_S && o_seg[6:0] == P_HEX[0])
    else $error("disabled speed page not s 0");
  AST_SPEED_ON: assert property (
    i_ce && page_live && i_page == PAGE_SPEED && i_drive_enabled
    |=> o_seg[5*SEG_W +: SEG_W] == P_LET_R && o_seg[6:0] == P_HEX[$past(i_speed_bcd[3:0])])
    else $error("enabled speed page not r value");
  AST_UPPER_ONLY: assert property (
    s_line_page |=> (o_seg[6:0] & LOWER_MASK) == '0 && o_seg[5*SEG_W +: SEG_W] == '0)
    else $error("lower segments used on line page");
  AST_DP_VIEW: assert property (
    s_line_page |=> o_dp == ($past(i_line_input_view) ? '1 : '0))
    else $error("decimal points disagree with view");
  AST_IN_FIRST: assert property (
    s_line_page ##0 i_line_input_view |=> o_seg[SEG_B] == $past(i_inputs[0]))
    else $error("first input segment wrong");
  AST_OUT_TENTH: assert property (
    s_line_page ##0 !i_line_input_view
    |=> o_seg[4*SEG_W + SEG_F] == $past(i_outputs[LINES-1]))
    else $error("tenth output segment wrong");

endmodule

// ### test/panel_viewer.sv
// Purpose: Viewer model that reads line states back from the panel digits.
// Assumes: Digit 0 is rightmost; segments and points are active high.
// Notes:   Decodes the line-status page only.
`timescale 1ns/10ps
module panel_viewer
  import panel_pkg::*;
(
  input  wire logic [panel_pkg::DIGITS*panel_pkg::SEG_W-1:0] i_seg,
  input  wire logic [panel_pkg::DIGITS-1:0]                  i_dp,
  output logic      [panel_pkg::LINES-1:0]                   o_lines,
  output logic                                               o_input_view
);
  import panel_pkg::*;
  always_comb
  begin
    for (int k = 0; k < LINES; k++)
      o_lines[k] = i_seg[SEG_W*(k/2) + ((k%2 != 0) ? SEG_F : SEG_B)];
  end
  assign o_input_view = &i_dp;
endmodule

// ### test/tb_top.sv
// Purpose: Self-checking bench for the panel monitor encoder.
// Assumes: Banner shortened to eight enabled cycles.
// Notes:   Inputs change 2 ns after each rising edge.
`timescale 1ns/10ps
module tb_top;
  import panel_pkg::*;
  localparam int unsigned BC = 8;
  localparam int SW = DIGITS*SEG_W;
  localparam logic [SW-1:0] BANNER = {P_BLANK, P_LET_R, P_HEX[14], P_HEX[10], P_HEX[13], P_LET_Y};
  logic            i_clk;
  logic            i_sys_rst;
  logic            i_ce;
  page_type        i_page;
  drive_state_type i_drive_state;
  logic [3:0]      i_link_code;
  logic            i_drive_enabled;
  logic [15:0]     i_speed_bcd;
  logic            i_line_input_view;
  logic [9:0]      i_inputs;
  logic [9:0]      i_outputs;
  logic            i_alarm_present;
  logic [7:0]      i_alarm_code;
  logic [SW-1:0]   o_seg;
  logic [5:0]      o_dp;
  logic [9:0]      seen_lines;
  logic            seen_input;
  int              check_count = 0;
  int              bad_count = 0;

  panel_monitor_display_encoder #(.BANNER_CYCLES(BC)) dut_u (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_page(i_page), .i_drive_state(i_drive_state),
    .i_link_code(i_link_code), .i_drive_enabled(i_drive_enabled), .i_speed_bcd(i_speed_bcd),
    .i_line_input_view(i_line_input_view), .i_inputs(i_inputs), .i_outputs(i_outputs),
    .i_alarm_present(i_alarm_present), .i_alarm_code(i_alarm_code), .o_seg(o_seg), .o_dp(o_dp));
  panel_viewer viewer_u (.i_seg(o_seg), .i_dp(o_dp), .o_lines(seen_lines),
    .o_input_view(seen_input));

  task automatic chk(input logic [SW-1:0] got, input logic [SW-1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step;
    @(posedge i_clk);
    #2;
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [SW-1:0] exp_lines(input logic [9:0] l);
    logic [SW-1:0] e;
    e = '0;
    for (int k = 0; k < 10; k++)
      e[7*(k/2) + ((k%2 != 0) ? SEG_F : SEG_B)] = l[k];
    return e;
  endfunction

  task automatic test_banner;
    for (int n = 1; n <= BC; n++)
    begin
      step;
      chk(o_seg, BANNER);
    end
    step;
    chk(o_seg, {7'h01, P_HEX[0], 28'h0});
    $display("banner test done");
  endtask

  task automatic test_servo;
    drive_state_type st [5] = '{DRV_INIT, DRV_READY, DRV_WAIT, DRV_RUN, DRV_STOP};
    logic [6:0] gl [5] = '{7'h01, 7'h41, 7'h49, 7'h3f, 7'h36};
    logic [3:0] lc [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    for (int i = 0; i < 5; i++)
    begin
      i_drive_state = st[i];
      i_link_code = lc[i];
      step;
      chk(o_seg, {gl[i], P_HEX[lc[i]], 28'h0});
    end
    $display("servo test done");
  endtask

  task automatic test_speed;
    i_page = PAGE_SPEED;
    i_speed_bcd = 16'h1907;
    step;
    chk(o_seg & {7'h7f, 28'h0, 7'h7f}, {P_LET_S, 28'h0, P_HEX[0]});
    i_drive_enabled = 1'b1;
    step;
    chk(o_seg & {7'h7f, 7'h0, 28'hfffffff},
      {P_LET_R, 7'h0, P_HEX[1], P_HEX[9], P_HEX[0], P_HEX[7]});
    i_speed_bcd = 16'h0000;
    step;
    chk(o_seg & {7'h7f, 7'h0, 28'hfffffff}, {P_LET_R, 7'h0, {4{P_HEX[0]}}});
    i_ce = 1'b0;
    i_drive_enabled = 1'b0;
    step;
    chk(o_seg & {7'h7f, 7'h0, 28'hfffffff}, {P_LET_R, 7'h0, {4{P_HEX[0]}}});
    i_ce = 1'b1;
    $display("speed test done");
  endtask

  task automatic test_lines;
    logic [9:0] l;
    i_page = PAGE_LINE;
    for (int v = 0; v < 2; v++)
      for (int k = 0; k <= 10; k++)
      begin
        l = (k < 10) ? (10'h001 << k) : 10'h281;
        i_line_input_view = v[0];
        i_inputs = v[0] ? l : ~l;
        i_outputs = v[0] ? ~l : l;
        step;
        chk(o_seg, exp_lines(l));
        chk({36'h0, o_dp}, {36'h0, {6{v[0]}}});
        chk({31'h0, seen_input, seen_lines}, {31'h0, v[0], l});
      end
    $display("line test done");
  endtask

  task automatic test_alarm;
    i_page = PAGE_SERVO;
    i_alarm_present = 1'b1;
    i_alarm_code = 8'h3c;
    step;
    chk(o_seg, {P_HEX[14], P_LET_R, 14'h0, P_HEX[3], P_HEX[12]});
    $display("alarm test done");
  endtask

  task automatic test_reset;
    i_sys_rst = 1'b1;
    step;
    chk(o_seg, '0);
    chk({36'h0, o_dp}, 42'h0);
    i_sys_rst = 1'b0;
    for (int n = 1; n <= BC; n++)
    begin
      step;
      chk(o_seg, BANNER);
    end
    step;
    chk(o_seg, {P_HEX[14], P_LET_R, 14'h0, P_HEX[3], P_HEX[12]});
    $display("reset test done");
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial
  begin
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_page = PAGE_SERVO;
    i_drive_state = DRV_INIT;
    i_link_code = 4'h0;
    i_drive_enabled = 1'b0;
    i_speed_bcd = 16'h0000;
    i_line_input_view = 1'b0;
    i_inputs = 10'h000;
    i_outputs = 10'h000;
    i_alarm_present = 1'b0;
    i_alarm_code = 8'h00;
    repeat (10) @(posedge i_clk);
    #2;
    i_sys_rst = 1'b0;
    test_banner;
    test_servo;
    test_speed;
    test_lines;
    test_alarm;
    test_reset;
    final_report;
  end

  initial
  begin
    repeat (500) @(posedge i_clk);
    bad_count++;
    final_report;
  end
endmodule
